//--- verif/art_timer_chk.sv
// Purpose: port checks of the auto-reload timer
// Assumes: master idles a cycle after each ack
// Notes: register contents are judged by the bench
`timescale 1ns/1ps
module art_timer_chk import art_pkg::*; (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	input wire logic i_rtc_clk,
	input wire logic i_cmp0,
	input wire logic o_wb_ack,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_irq
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	// a request the slave has not answered yet
	sequence take_s;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	// a read of one word address
	sequence rd_s(logic [5:0] w);
		take_s ##0 (!i_wb_we && i_wb_adr[7:2] == w);
	endsequence
	ack_next_a: assert property (take_s |=> o_wb_ack)
		else $error("ack late");
	ack_once_a: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack too long");
	ack_cause_a: assert property (
		!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
		else $error("ack without request");
	dat_hold_a: assert property (
		!take_s |=> $stable(o_wb_dat))
		else $error("read data moved");
	dat_lane_a: assert property (
		o_wb_ack |-> o_wb_dat[31:8] == 24'h000000)
		else $error("upper lanes set");
	unmap_zero_a: assert property (
		rd_s(6'h38) |=> o_wb_dat == 32'h00000000)
		else $error("hole read nonzero");
	clkc_pad_a: assert property (
		rd_s(ART_ADR_CLKC[7:2]) |=> o_wb_dat[6:2] == 5'h00)
		else $error("clock control pad set");
	// flags only fall by a write, so the request stays up meanwhile
	flag_keep_a: assert property (
		o_irq && !(i_wb_cyc && i_wb_stb && i_wb_we) |=> o_irq)
		else $error("irq dropped alone");
endmodule

//--- verif/tb_art_timer.sv
// Purpose: self-checking bench of the auto-reload timer
// Assumes: bus answer comes one cycle after a request
// Notes: counts that drift with sync delay are given a range
`timescale 1ns/1ps
module tb_art_timer import art_pkg::*;;
	logic i_ref_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_wb_cyc = 1'b0;
	logic i_wb_stb = 1'b0;
	logic i_wb_we = 1'b0;
	logic [7:0] i_wb_adr = 8'h00;
	logic [31:0] i_wb_dat = 32'h0;
	logic [3:0] i_wb_sel = 4'h0;
	logic i_rtc_clk = 1'b0;
	logic i_cmp0 = 1'b0;
	logic o_wb_ack;
	logic o_irq;
	logic [31:0] o_wb_dat;
	int fail_count = 0;
	int comparisons = 0;
	int seed = 83;
	int rises;
	logic [15:0] expq[$];
	logic [7:0] lo[4];
	logic [7:0] hi[4];
	art_timer art_timer_inst (.i_ref_clk, .i_rst_b, .i_wb_cyc, .i_wb_stb,
		.i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel, .i_rtc_clk, .i_cmp0,
		.o_wb_ack, .o_wb_dat, .o_irq);
	// 25 MHz reference
	initial begin
		forever #20 i_ref_clk = ~i_ref_clk;
	end
	task automatic miss(input string m);
		fail_count++;
		$display("Error at %0t: %s", $time, m);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask
	// one classic cycle: hold until ack is seen, then idle a cycle
	task automatic bus(input logic w, input logic [7:0] a, d);
		int n;
		n = 0;
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= w;
		i_wb_adr <= a;
		i_wb_dat <= {24'h000000, d};
		i_wb_sel <= 4'h1;
		idle(1);
		while (o_wb_ack !== 1'b1 && n < 20) begin
			idle(1);
			n++;
		end
		if (n >= 20) begin
			miss("bus answer timeout");
		end
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		idle(1);
	endtask
	task automatic wr(input logic [7:0] a, d);
		bus(1'b1, a, d);
	endtask
	// a read notes its accepted range before the request goes out
	task automatic rd(input logic [7:0] a, l, h);
		expq.push_back({l, h});
		bus(1'b0, a, 8'h00);
	endtask
	task automatic chk_dat(input logic [31:0] d);
		logic [15:0] e;
		if (expq.size() == 0) begin
			miss("read answer without note");
			return;
		end
		e = expq.pop_front();
		comparisons++;
		if ((d >= {24'h0, e[15:8]} && d <= {24'h0, e[7:0]}) !== 1'b1) begin
			miss($sformatf("read %h outside %h..%h", d, e[15:8], e[7:0]));
		end
	endtask
	task automatic chk_irq(input logic x);
		comparisons++;
		if (o_irq !== x) begin
			miss("interrupt level");
		end
	endtask
	// read answers are taken at the ack edge
	always @(posedge i_ref_clk) begin
		if (o_wb_ack === 1'b1 && i_wb_we === 1'b0) begin
			chk_dat(o_wb_dat);
		end
	end
	// whole run needs about 1300 cycles
	initial begin
		idle(20000);
		miss("timeout");
		conclude();
	end
	initial begin
		logic [7:0] adr[7];
		adr = '{ART_ADR_CTRL, ART_ADR_CNT_L, ART_ADR_CNT_H, ART_ADR_RLD_L,
			ART_ADR_RLD_H, ART_ADR_CLKC, 8'he0};
		lo = '{8'h13, 8'h06, 8'h00, 8'h00};
		hi = '{8'h16, 8'h08, 8'h00, 8'h00};
		idle(12);
		i_rst_b <= 1'b1;
		idle(1);
		// all clear after reset; a write to a hole is lost
		wr(8'he0, 8'h5a);
		foreach (adr[i]) begin
			rd(adr[i], 8'h00, 8'h00);
		end
		// 16-bit run through 0xffff
		wr(ART_ADR_CLKC, 8'h83);
		wr(ART_ADR_RLD_L, 8'h34);
		wr(ART_ADR_RLD_H, 8'h12);
		wr(ART_ADR_CNT_L, 8'hfa);
		wr(ART_ADR_CNT_H, 8'hff);
		chk_irq(1'b0);
		wr(ART_ADR_CTRL, 8'h04);
		idle(10);
		rd(ART_ADR_CTRL, 8'hc4, 8'hc4);
		chk_irq(1'b1);
		rd(ART_ADR_CNT_H, 8'h12, 8'h12);
		rd(ART_ADR_CNT_L, 8'h35, 8'h60);
		wr(ART_ADR_CTRL, 8'h00);
		chk_irq(1'b0);
		// low wrap alone: carry, low flag, irq only with its enable
		wr(ART_ADR_CNT_L, 8'hf8);
		wr(ART_ADR_CTRL, 8'h04);
		idle(12);
		rd(ART_ADR_CTRL, 8'h44, 8'h44);
		chk_irq(1'b0);
		wr(ART_ADR_CTRL, 8'h64);
		chk_irq(1'b1);
		rd(ART_ADR_CNT_H, 8'h13, 8'h13);
		wr(ART_ADR_CTRL, 8'h00);
		// split with run off: low keeps going, high must hold
		wr(ART_ADR_CNT_H, 8'h55);
		wr(ART_ADR_CNT_L, 8'hf8);
		wr(ART_ADR_CTRL, 8'h08);
		idle(12);
		rd(ART_ADR_CNT_H, 8'h55, 8'h55);
		// both flags are read to tell which byte wrapped
		rd(ART_ADR_CTRL, 8'h48, 8'h48);
		rd(ART_ADR_CNT_L, 8'h35, 8'h60);
		chk_irq(1'b0);
		wr(ART_ADR_CTRL, 8'h68);
		chk_irq(1'b1);
		wr(ART_ADR_CTRL, 8'h00);
		// each external code; comparator edges are random
		wr(ART_ADR_CLKC, 8'h80);
		for (int c = 0; c < 4; c++) begin
			wr(ART_ADR_CNT_L, 8'h00);
			wr(ART_ADR_CTRL, 8'h04 | 8'(c));
			rises = 0;
			for (int i = 0; i < 120; i++) begin
				logic b;
				b = 1'($random(seed));
				if (b && !i_cmp0) rises++;
				i_cmp0 <= b;
				i_rtc_clk <= i[0];
				idle(2);
			end
			i_cmp0 <= 1'b0;
			idle(6);
			wr(ART_ADR_CTRL, 8'h00);
			if (c == 3) begin
				lo[3] = 8'(rises);
				hi[3] = 8'(rises);
			end
			rd(ART_ADR_CNT_L, lo[c], hi[c]);
		end
		// capture on a comparator rise, then on the rtc/8 tick;
		// the count runs every clock, far faster than the trigger
		wr(ART_ADR_CLKC, 8'h81);
		wr(ART_ADR_CNT_L, 8'h00);
		wr(ART_ADR_CTRL, 8'h17);
		i_cmp0 <= 1'b1;
		idle(10);
		rd(ART_ADR_CTRL, 8'h97, 8'h97);
		chk_irq(1'b1);
		rd(ART_ADR_RLD_L, 8'h02, 8'h0c);
		rd(ART_ADR_RLD_H, 8'h55, 8'h55);
		i_cmp0 <= 1'b0;
		wr(ART_ADR_CTRL, 8'h15);
		chk_irq(1'b0);
		for (int i = 0; i < 40; i++) begin
			i_rtc_clk <= i[0];
			idle(2);
		end
		rd(ART_ADR_CTRL, 8'h95, 8'h95);
		conclude();
	end
endmodule
bind art_timer art_timer_chk art_timer_chk_inst (.i_ref_clk, .i_rst_b,
	.i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel,
	.i_rtc_clk, .i_cmp0, .o_wb_ack, .o_wb_dat, .o_irq);

//--- verilog/art_pkg.sv
// Purpose: shared constants and types of the auto-reload timer
// Assumes: 32-bit classic bus slave, byte addresses, 8-bit data in [7:0]
// Notes: the list below states the block's contract in short form
//
// Contract
// [RULE_01] count is two bytes forming 16 bits
// [RULE_02] split clear: 16-bit wrap reloads, sets high flag
// [RULE_03] every 16-bit overflow interrupts when enabled
// [RULE_04] 16-bit mode: low wrap interrupts with enable
// [RULE_05] split set: two independent 8-bit reload counters
// [RULE_06] split mode: run gates only high byte
// [RULE_07] per-byte clock select, external source codes
// [RULE_08] rtc/8 and comparator synchronised before use
// [RULE_09] split mode: each byte wrap sets flag
// [RULE_10] split mode: interrupt on high, low optional
// [RULE_11] flags never cleared by hardware
// [RULE_12] software checks both flags for source
// [RULE_13] capture enable bit enters capture mode
// [RULE_14] software uses 16-bit mode for capture
// [RULE_15] capture trigger: comparator edge or rtc/8
// [RULE_16] capture copies count to reload, sets flag
// [RULE_17] count clock should outpace capture clock
// [RULE_18] control register at 0xc8, fixed layout
// [RULE_19] byte wraps set flags in any mode
// [RULE_20] 16-bit mode counts on low clock, run gated
package art_pkg;

	// register byte addresses
	localparam logic [7:0] ART_ADR_CTRL = 8'hc8;
	localparam logic [7:0] ART_ADR_CNT_L = 8'hcc;
	localparam logic [7:0] ART_ADR_CNT_H = 8'hd0;
	localparam logic [7:0] ART_ADR_RLD_L = 8'hd4;
	localparam logic [7:0] ART_ADR_RLD_H = 8'hd8;
	localparam logic [7:0] ART_ADR_CLKC = 8'hdc;

	// reset values
	localparam logic [7:0] ART_CTRL_RST = 8'h00;
	localparam logic [7:0] ART_CLKC_RST = 8'h00;
	localparam logic [7:0] ART_BYTE_RST = 8'h00;

	// byte limits
	localparam logic [7:0] ART_BYTE_MAX = 8'hff;
	localparam logic [7:0] ART_BYTE_ONE = 8'h01;

	// system clock divided by 12: enable every twelfth cycle
	localparam int ART_DIV12 = 12;
	localparam logic [3:0] ART_DIV12_TOP = 4'(ART_DIV12 - 1);
	// real-time clock divided by 8
	localparam int ART_RTC_DIV = 8;
	localparam logic [2:0] ART_RTC_TOP = 3'(ART_RTC_DIV - 1);

	// external clock select codes
	typedef enum logic [1:0] {
		ART_XCLK_SYS12 = 2'b00,
		ART_XCLK_RTC8 = 2'b01,
		ART_XCLK_RSVD = 2'b10,
		ART_XCLK_CMP0 = 2'b11
	} art_xclk_e;

	// control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic high_overflow_flag;
		logic low_overflow_flag;
		logic low_overflow_irq_enable;
		logic capture_enable_bit;
		logic split_mode_bit;
		logic run_control_bit;
		logic [1:0] external_clock_select;
	} art_ctrl_s;

	// clock control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic timer_irq_enable;
		logic [4:0] unused;
		logic high_byte_clock_select;
		logic low_byte_clock_select;
	} art_clkc_s;

	// flag set events of both bytes travelling together
	typedef struct packed {
		logic low;
		logic high;
	} art_pair_s;

endpackage

//--- verilog/art_sync.sv
// Purpose: two-flop synchroniser for the asynchronous timer inputs
// Assumes: inputs are slow against the reference clock
// Notes: only the second stage leaves this module
`timescale 1ns/1ps
module art_sync import art_pkg::*; (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic [1:0] i_async,
	output logic [1:0] o_sync
);

	logic [1:0] meta_r;
	logic [1:0] sync_r;

	// first stage feeds the second stage and nothing else
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			meta_r <= 2'h0;
			sync_r <= 2'h0;
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;

endmodule

//--- verilog/art_timer.sv
// Purpose: 16-bit auto-reload timer with split and capture modes
// Assumes: classic single-cycle bus master, one clock
// Notes: all registers are 8 bits wide in data lane 0
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
module art_timer import art_pkg::*; (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	input wire logic i_rtc_clk,
	input wire logic i_cmp0,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat,
	output logic o_irq
);

	// address match, used by both read and write decode
	function automatic logic art_hit(
		input logic [7:0] adr,
		input logic [7:0] reg_adr
	);
		art_hit = (adr[7:2] == reg_adr[7:2]);
	endfunction

	// register state
	art_ctrl_s ctrl_r;
	art_clkc_s clkc_r;
	logic [7:0] cnt_l_r;
	logic [7:0] cnt_h_r;
	logic [7:0] rld_l_r;
	logic [7:0] rld_h_r;

	// bus state
	logic ack_r;
	logic [31:0] rdat_r;

	// source conditioning state
	logic [1:0] sync_w;
	logic [1:0] prev_r;
	logic [2:0] rtc_div_r;
	logic [3:0] div12_r;

	// next values
	logic [7:0] cnt_l_nxt;
	logic [7:0] cnt_h_nxt;
	art_pair_s set_w;

	// bus decode
	wire req_w = i_wb_cyc & i_wb_stb & ~ack_r;
	wire wr_w = req_w & i_wb_we & i_wb_sel[0];
	wire [7:0] wdat_w = i_wb_dat[7:0];
	wire wr_ctrl_w = wr_w & art_hit(i_wb_adr, ART_ADR_CTRL);
	wire wr_cnt_l_w = wr_w & art_hit(i_wb_adr, ART_ADR_CNT_L);
	wire wr_cnt_h_w = wr_w & art_hit(i_wb_adr, ART_ADR_CNT_H);
	wire wr_rld_l_w = wr_w & art_hit(i_wb_adr, ART_ADR_RLD_L);
	wire wr_rld_h_w = wr_w & art_hit(i_wb_adr, ART_ADR_RLD_H);
	wire wr_clkc_w = wr_w & art_hit(i_wb_adr, ART_ADR_CLKC);
	wire art_ctrl_s wctrl_w = art_ctrl_s'(wdat_w);
	wire art_clkc_s wclkc_w = art_clkc_s'(wdat_w);

	// read selection; unmapped words read as zero
	wire [7:0] rsel_w =
		art_hit(i_wb_adr, ART_ADR_CTRL) ? 8'(ctrl_r) :
		art_hit(i_wb_adr, ART_ADR_CNT_L) ? cnt_l_r :
		art_hit(i_wb_adr, ART_ADR_CNT_H) ? cnt_h_r :
		art_hit(i_wb_adr, ART_ADR_RLD_L) ? rld_l_r :
		art_hit(i_wb_adr, ART_ADR_RLD_H) ? rld_h_r :
		art_hit(i_wb_adr, ART_ADR_CLKC) ? 8'(clkc_r) :
		8'h00;

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			ack_r <= 1'b0;
			rdat_r <= 32'h0000_0000;
		end else begin
			ack_r <= req_w;
			if (req_w) begin
				rdat_r <= {24'h00_0000, rsel_w};
			end
		end
	end

	assign o_wb_ack = ack_r;
	assign o_wb_dat = rdat_r;

	// pins from outside the clock domain
	art_sync u_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_async({i_cmp0, i_rtc_clk}),
		.o_sync(sync_w)
	); // see [RULE_08]

	// edge history taken from the second synchroniser stage
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			prev_r <= 2'h0;
		end else begin
			prev_r <= sync_w;
		end
	end

	wire rtc_rise_w = sync_w[0] & ~prev_r[0];
	wire cmp_rise_w = sync_w[1] & ~prev_r[1];

	// real-time clock divided by 8, counted in the system domain
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			rtc_div_r <= 3'h0;
		end else if (rtc_rise_w) begin
			rtc_div_r <= rtc_div_r + 3'h1;
		end
	end

	wire rtc8_w = rtc_rise_w & (rtc_div_r == ART_RTC_TOP); // see [RULE_08]

	// system clock divided by 12 as a one-cycle enable
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			div12_r <= 4'h0;
		end else if (div12_r == ART_DIV12_TOP) begin
			div12_r <= 4'h0;
		end else begin
			div12_r <= div12_r + 4'h1;
		end
	end

	wire sys12_w = (div12_r == ART_DIV12_TOP);

	// external source; the reserved code never ticks
	wire ext_tick_w =
		(ctrl_r.external_clock_select == ART_XCLK_SYS12) ? sys12_w :
		(ctrl_r.external_clock_select == ART_XCLK_RTC8) ? rtc8_w :
		(ctrl_r.external_clock_select == ART_XCLK_CMP0) ? cmp_rise_w :
		1'b0; // see [RULE_07]

	// per-byte tick: system clock when the select bit is one
	wire tick_l_w = clkc_r.low_byte_clock_select | ext_tick_w; // see [RULE_07]
	wire tick_h_w = clkc_r.high_byte_clock_select | ext_tick_w; // see [RULE_07]

	// capture trigger: upper select bit picks comparator, else rtc/8
	wire cap_w = ctrl_r.capture_enable_bit &
		(ctrl_r.external_clock_select[1] ? cmp_rise_w : rtc8_w);
	// see [RULE_13] [RULE_15]

	wire low_max_w = (cnt_l_r == ART_BYTE_MAX);
	wire high_max_w = (cnt_h_r == ART_BYTE_MAX);

	// counting and wrap detection
	always_comb begin
		cnt_l_nxt = cnt_l_r;
		cnt_h_nxt = cnt_h_r;
		set_w = '0;
		if (!ctrl_r.split_mode_bit) begin
			// one 16-bit counter on the low clock, gated by run
			if (ctrl_r.run_control_bit && tick_l_w) begin // see [RULE_20]
				if (low_max_w) begin
					set_w.low = 1'b1; // see [RULE_19]
					if (high_max_w) begin
						// full wrap loads both reload bytes
						cnt_l_nxt = rld_l_r; // see [RULE_02]
						cnt_h_nxt = rld_h_r; // see [RULE_01]
						set_w.high = 1'b1; // see [RULE_02]
					end else begin
						cnt_l_nxt = ART_BYTE_RST;
						cnt_h_nxt = cnt_h_r + ART_BYTE_ONE; // see [RULE_01]
					end
				end else begin
					cnt_l_nxt = cnt_l_r + ART_BYTE_ONE;
				end
			end
		end else begin
			// low byte runs regardless of run control
			if (tick_l_w) begin // see [RULE_06]
				if (low_max_w) begin
					cnt_l_nxt = rld_l_r; // see [RULE_05]
					set_w.low = 1'b1; // see [RULE_09]
				end else begin
					cnt_l_nxt = cnt_l_r + ART_BYTE_ONE;
				end
			end
			// high byte is the only one gated by run control
			if (ctrl_r.run_control_bit && tick_h_w) begin // see [RULE_06]
				if (high_max_w) begin
					cnt_h_nxt = rld_h_r; // see [RULE_05]
					set_w.high = 1'b1; // see [RULE_09] [RULE_19]
				end else begin
					cnt_h_nxt = cnt_h_r + ART_BYTE_ONE;
				end
			end
		end
		// a capture event also raises the high flag
		if (cap_w) begin
			set_w.high = 1'b1; // see [RULE_16]
		end
	end

	// count bytes; a software write replaces the step
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			cnt_l_r <= ART_BYTE_RST;
			cnt_h_r <= ART_BYTE_RST;
		end else begin
			cnt_l_r <= wr_cnt_l_w ? wdat_w : cnt_l_nxt;
			cnt_h_r <= wr_cnt_h_w ? wdat_w : cnt_h_nxt;
		end
	end

	// reload bytes; capture wins over a same-cycle write so that
	// a measurement is never lost to software
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			rld_l_r <= ART_BYTE_RST;
			rld_h_r <= ART_BYTE_RST;
		end else if (cap_w) begin
			rld_l_r <= cnt_l_r; // see [RULE_16]
			rld_h_r <= cnt_h_r; // see [RULE_16]
		end else begin
			if (wr_rld_l_w) begin
				rld_l_r <= wdat_w;
			end
			if (wr_rld_h_w) begin
				rld_h_r <= wdat_w;
			end
		end
	end

	// flag next values: hardware set wins over software clear,
	// and hardware itself never clears them
	wire tf_h_nxt = set_w.high |
		(wr_ctrl_w ? wctrl_w.high_overflow_flag :
		ctrl_r.high_overflow_flag); // see [RULE_11]
	wire tf_l_nxt = set_w.low |
		(wr_ctrl_w ? wctrl_w.low_overflow_flag :
		ctrl_r.low_overflow_flag); // see [RULE_11]

	// control register
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			ctrl_r <= art_ctrl_s'(ART_CTRL_RST);
		end else begin
			ctrl_r.high_overflow_flag <= tf_h_nxt;
			ctrl_r.low_overflow_flag <= tf_l_nxt;
			if (wr_ctrl_w) begin // see [RULE_18]
				ctrl_r.low_overflow_irq_enable <=
					wctrl_w.low_overflow_irq_enable;
				ctrl_r.capture_enable_bit <=
					wctrl_w.capture_enable_bit; // see [RULE_13]
				ctrl_r.split_mode_bit <= wctrl_w.split_mode_bit;
				ctrl_r.run_control_bit <= wctrl_w.run_control_bit;
				ctrl_r.external_clock_select <=
					wctrl_w.external_clock_select;
			end
		end
	end

	// clock control register; unused bits stay zero
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			clkc_r <= art_clkc_s'(ART_CLKC_RST);
		end else if (wr_clkc_w) begin
			clkc_r.timer_irq_enable <= wclkc_w.timer_irq_enable;
			clkc_r.high_byte_clock_select <=
				wclkc_w.high_byte_clock_select;
			clkc_r.low_byte_clock_select <=
				wclkc_w.low_byte_clock_select;
		end
	end

	// request level under the timer enable: high flag always, low flag only when enabled;
	// the same gating serves both modes
	assign o_irq = clkc_r.timer_irq_enable &
		(ctrl_r.high_overflow_flag |
		(ctrl_r.low_overflow_irq_enable &
		ctrl_r.low_overflow_flag)); // see [RULE_03] [RULE_04] [RULE_10]

endmodule
